// [hdl/rip_cycle_count.sv]
// Counts consecutive cycles of a level and flags the Nth
`default_nettype none
module rip_cycle_count #(
  parameter int              WIDTH = 11,
  parameter logic [WIDTH-1:0] LIMIT = '1
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Level to time
  input  wire logic run,
  output logic      done
);

  logic [WIDTH-1:0] cnt_q;

  // High in the cycle where run has been high LIMIT+1 cycles
  assign done = run && (cnt_q == LIMIT);

  always_ff @(posedge clock) begin
    if (sys_rst || !run || done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// [hdl/rip_pkg.sv]
// Constants and types shared by the reset, idle and power-down controller
`default_nettype none
package rip_pkg;

  // ==========================================================
  // Register map (AXI4-Lite byte addresses)
  localparam int          RIP_ADDR_W   = 12;
  localparam logic [7:0]  POWER_CONFIG_REG_IDX     = 8'h87;
  localparam logic [11:0] POWER_CONFIG_REG_ADDR    = {2'b00, POWER_CONFIG_REG_IDX, 2'b00};
  localparam logic [11:0] AUX_ADDR     = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;

  // ==========================================================
  // Field positions and reset values
  localparam int          IDLE_BIT     = 0;
  localparam int          PD_BIT       = 1;
  localparam int          GF0_BIT      = 2;
  localparam int          GF1_BIT      = 3;
  localparam int          SMOD0_BIT    = 6;
  localparam int          SMOD1_BIT    = 7;
  localparam int          BOOT_MAP_BIT = 0;
  localparam logic [7:0]  POWER_CONFIG_REG_RESET   = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ==========================================================
  // Timing, in oscillator periods; the clock is the oscillator
  localparam int CLK_PERIOD_NS    = 10;
  localparam int OSC_PERIOD_NS    = 10;
  localparam int OSC_PER_MACHINE  = 12;
  localparam int WARM_MIN_MACHINE = 2;
  localparam int WARM_MIN_OSC     = WARM_MIN_MACHINE * OSC_PER_MACHINE;
  localparam int WDT_PULSE_OSC    = 96;
  localparam int KB_WAKE_OSC      = 1024;
  // Least times round up
  localparam int WARM_MIN_CLKS    = (WARM_MIN_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_PULSE_CLKS   = (WDT_PULSE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int KB_WAKE_CLKS     = (KB_WAKE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 11;

  // ==========================================================
  // Operating modes
  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_PDOWN,
    ST_WAIT_RELEASE,
    ST_KB_DELAY
  } rip_mode_t;

endpackage
`default_nettype wire

// [hdl/rip_power_ctrl.sv]
// Reset qualification, idle and power-down control with AXI4-Lite registers
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module rip_power_ctrl
  import rip_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // AXI4-Lite write address and data
  input  wire logic [RIP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [RIP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Reset pin (open drain) and watchdog
  input  wire logic                  reset_pin_in,
  output logic                       reset_pin_out,
  output logic                       reset_pin_oe,
  input  wire logic                  watchdog_fire,
  // Wake sources
  input  wire logic                  irq_wake_req,
  input  wire logic                  ext_irq_line_0,
  input  wire logic                  ext_irq_line_1,
  input  wire logic                  ext_irq_en_0,
  input  wire logic                  ext_irq_en_1,
  input  wire logic                  keyboard_wake_inputs,
  input  wire logic                  boot_jump_fuse,
  // Core and clock control
  output logic                       core_reset,
  output logic                       first_fetch,
  output logic [15:0]                fetch_addr,
  output logic                       cpu_clk_en,
  output logic                       periph_clk_en,
  output logic                       osc_enable,
  output logic                       ram_access_en,
  output logic                       boot_map_enable,
  // Pin state control
  output logic                       port0_float,
  output logic                       mmc_float,
  output logic                       ports_high,
  output logic                       pin_hold
);

  // ==========================================================
  // Declarations
  rip_mode_t                state_q, state_d;
  logic                     awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]               bresp_q, rresp_q;
  logic [31:0]              rdata_q, wdata_q;
  logic [3:0]               wstrb_q;
  logic [RIP_ADDR_W-1:0]    awaddr_q;
  logic                     wr_go, wr_power_config_reg, wr_aux;
  logic                     idle_bit_q, pd_bit_q, gf0_q, gf1_q, smod0_q, smod1_q;
  logic                     boot_map_q;
  logic                     rst_meta_q, rst_sync_q, rst_level;
  logic                     core_reset_q, first_fetch_q, wdt_drive_q;
  logic                     warm_done, wdt_done, kb_done;
  logic                     cpu_clk_q, periph_clk_q, osc_q, ram_block_q, pin_hold_q;
  logic                     port0_float_q, mmc_float_q, ports_high_q;
  logic                     pd_wake_int, pd_wake_kb;
  logic [31:0]              rd_word;

  // ==========================================================
  // AXI4-Lite write channel
  assign wr_go   = !awready_q && !wready_q && !bvalid_q;
  assign wr_power_config_reg = wr_go && (awaddr_q == POWER_CONFIG_REG_ADDR) && wstrb_q[0];
  assign wr_aux  = wr_go && (awaddr_q == AUX_ADDR) && wstrb_q[0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (awaddr_q == POWER_CONFIG_REG_ADDR || awaddr_q == AUX_ADDR || awaddr_q == STATUS_ADDR)
                    ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      POWER_CONFIG_REG_ADDR:   rd_word = {24'h000000, smod1_q, smod0_q, 2'b00, gf1_q, gf0_q, pd_bit_q, idle_bit_q};
      AUX_ADDR:    rd_word = {31'h00000000, boot_map_q};
      STATUS_ADDR: rd_word = {26'h0000000, ram_block_q, wdt_drive_q, core_reset_q, state_q};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= (s_axi_araddr == POWER_CONFIG_REG_ADDR || s_axi_araddr == AUX_ADDR || s_axi_araddr == STATUS_ADDR)
                   ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ==========================================================
  // Reset pin qualification
  // two-stage synchronizer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= reset_pin_in;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_level = rst_sync_q || wdt_drive_q;

  // hold time, same count in double-speed mode
  rip_cycle_count #(
    .WIDTH (CNT_W),
    .LIMIT (CNT_W'(WARM_MIN_CLKS - 1))
  ) u_warm_cnt (
    .clock   (clock),
    .sys_rst (sys_rst),
    .run     (rst_level && !core_reset_q),
    .done    (warm_done)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_reset_q  <= 1'b1;
      port0_float_q <= 1'b1;
      mmc_float_q   <= 1'b1;
      ports_high_q  <= 1'b1;
      first_fetch_q <= 1'b0;
    end else begin
      core_reset_q  <= warm_done || (core_reset_q && rst_level);
      // reset pin states track internal reset
      port0_float_q <= warm_done || (core_reset_q && rst_level);
      mmc_float_q   <= warm_done || (core_reset_q && rst_level);
      ports_high_q  <= warm_done || (core_reset_q && rst_level);
      // fetch from the reset vector on release
      first_fetch_q <= core_reset_q && !rst_level;
    end
  end

  // ==========================================================
  // Watchdog reset-out pulse
  rip_cycle_count #(
    .WIDTH (CNT_W),
    .LIMIT (CNT_W'(WDT_PULSE_CLKS - 1))
  ) u_wdt_cnt (
    .clock   (clock),
    .sys_rst (sys_rst),
    .run     (wdt_drive_q),
    .done    (wdt_done)
  );

  // fixed-length pulse onto the reset pin
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdt_drive_q <= 1'b0;
    end else if (wdt_done) begin
      wdt_drive_q <= 1'b0;
    end else if (watchdog_fire) begin
      wdt_drive_q <= 1'b1;
    end
  end

  // ==========================================================
  // Power configuration bits
  assign pd_wake_int = (ext_irq_line_0 && ext_irq_en_0) || (ext_irq_line_1 && ext_irq_en_1);
  assign pd_wake_kb  = keyboard_wake_inputs;

  // reset pin clears requests without the clock
  // also restarts oscillator via the mode logic
  always_ff @(posedge clock or posedge reset_pin_in) begin
    if (reset_pin_in) begin
      idle_bit_q <= 1'b0;
      pd_bit_q   <= 1'b0;
    end else if (sys_rst || core_reset_q) begin
      idle_bit_q <= POWER_CONFIG_REG_RESET[IDLE_BIT];
      pd_bit_q   <= POWER_CONFIG_REG_RESET[PD_BIT];
    end else if (wr_power_config_reg) begin
      // software set wins over a same-cycle hardware clear
      idle_bit_q <= wdata_q[IDLE_BIT];
      pd_bit_q   <= wdata_q[PD_BIT];
    end else if (state_q == ST_IDLE && irq_wake_req) begin
      idle_bit_q <= 1'b0;
    end else if (state_q == ST_PDOWN && (pd_wake_int || pd_wake_kb)) begin
      // both cleared so idle does not follow
      idle_bit_q <= 1'b0;
      pd_bit_q   <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || core_reset_q) begin
      gf0_q   <= POWER_CONFIG_REG_RESET[GF0_BIT];
      gf1_q   <= POWER_CONFIG_REG_RESET[GF1_BIT];
      smod0_q <= POWER_CONFIG_REG_RESET[SMOD0_BIT];
      smod1_q <= POWER_CONFIG_REG_RESET[SMOD1_BIT];
    end else if (wr_power_config_reg) begin
      gf0_q   <= wdata_q[GF0_BIT];
      gf1_q   <= wdata_q[GF1_BIT];
      smod0_q <= wdata_q[SMOD0_BIT];
      smod1_q <= wdata_q[SMOD1_BIT];
    end
  end

  // boot mapping reloads from the fuse during reset
  always_ff @(posedge clock) begin
    if (sys_rst || core_reset_q) begin
      boot_map_q <= boot_jump_fuse;
    end else if (wr_aux) begin
      boot_map_q <= wdata_q[BOOT_MAP_BIT];
    end
  end

  // ==========================================================
  // Mode sequencing
  rip_cycle_count #(
    .WIDTH (CNT_W),
    .LIMIT (CNT_W'(KB_WAKE_CLKS - 1))
  ) u_kb_cnt (
    .clock   (clock),
    .sys_rst (sys_rst),
    .run     (state_q == ST_KB_DELAY),
    .done    (kb_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (pd_bit_q) begin
          state_d = ST_PDOWN;
        end else if (idle_bit_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!idle_bit_q || pd_bit_q) begin
          state_d = pd_bit_q ? ST_PDOWN : ST_RUN;
        end
      end
      ST_PDOWN: begin
        // interrupt lines resume on release, keys after a delay
        if (pd_wake_int) begin
          state_d = ST_WAIT_RELEASE;
        end else if (pd_wake_kb) begin
          state_d = ST_KB_DELAY;
        end else if (!pd_bit_q) begin
          state_d = ST_RUN;
        end
      end
      ST_WAIT_RELEASE: begin
        if (!pd_wake_int || rst_level) begin
          state_d = ST_RUN;
        end
      end
      ST_KB_DELAY: begin
        if (kb_done || rst_level) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // CPU clock frozen, peripherals keep running
  // power-down stops oscillator and all clocks
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q      <= ST_RUN;
      cpu_clk_q    <= 1'b1;
      periph_clk_q <= 1'b1;
      osc_q        <= 1'b1;
      pin_hold_q   <= 1'b0;
    end else begin
      state_q      <= state_d;
      cpu_clk_q    <= (state_d == ST_RUN);
      periph_clk_q <= (state_d != ST_PDOWN);
      osc_q        <= (state_d != ST_PDOWN);
      // pins keep presenting their data in low power
      pin_hold_q   <= (state_d != ST_RUN);
    end
  end

  // no RAM access between wake by reset and internal reset
  always_ff @(posedge clock) begin
    if (sys_rst || core_reset_q) begin
      ram_block_q <= 1'b0;
    // Pin level, not the synchronized one: the mode is left before the synchronizer catches up
    end else if (state_q != ST_RUN && reset_pin_in) begin
      ram_block_q <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  // Open drain: only ever pulls high when enabled
  assign reset_pin_out   = wdt_drive_q;
  assign reset_pin_oe    = wdt_drive_q;
  assign core_reset      = core_reset_q;
  assign first_fetch     = first_fetch_q;
  assign fetch_addr      = RESET_VECTOR;
  assign cpu_clk_en      = cpu_clk_q;
  assign periph_clk_en   = periph_clk_q;
  assign osc_enable      = osc_q;
  assign ram_access_en   = !ram_block_q;
  assign boot_map_enable = boot_map_q;
  assign port0_float     = port0_float_q;
  assign mmc_float       = mmc_float_q;
  assign ports_high      = ports_high_q;
  assign pin_hold        = pin_hold_q;

  // ==========================================================
  // Assertions
  a_reset_vector: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(core_reset_q) |-> first_fetch_q && (fetch_addr == RESET_VECTOR))
    else $error("first fetch missing on reset release");

  a_warm_apply: assert property (@(posedge clock) disable iff (sys_rst)
    ($rose(rst_level) && !core_reset_q) ##1 rst_level[*8] ##1 rst_level[*8] ##1 rst_level[*8] |=> core_reset_q)
    else $error("qualified reset level did not reset the core");

  a_warm_short: assert property (@(posedge clock) disable iff (sys_rst)
    ($rose(rst_level) && !core_reset_q) |-> !core_reset_q[*8])
    else $error("core reset asserted before hold time");

  a_wdt_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(wdt_drive_q) |-> (reset_pin_oe throughout ##95 1'b1) ##1 !reset_pin_oe)
    else $error("watchdog pulse length wrong");

  a_reset_pins: assert property (@(posedge clock) disable iff (sys_rst)
    core_reset_q |-> port0_float_q && mmc_float_q && ports_high_q)
    else $error("pin states wrong during reset");

  a_idle_clocks: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_IDLE |-> !cpu_clk_q && periph_clk_q && osc_q && pin_hold_q)
    else $error("idle clock gating wrong");

  a_pd_clocks: assert property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_PDOWN |-> !cpu_clk_q && !periph_clk_q && !osc_q && pin_hold_q)
    else $error("power-down clock gating wrong");

  a_pd_precedence: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_RUN && pd_bit_q && idle_bit_q && !rst_level) |=> state_q == ST_PDOWN)
    else $error("power-down did not take precedence");

  a_idle_wake: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_IDLE && irq_wake_req && !wr_power_config_reg && !core_reset_q) |=> !idle_bit_q ##1 cpu_clk_q)
    else $error("interrupt did not end idle");

  a_async_clear: assert property (@(posedge clock) disable iff (sys_rst)
    reset_pin_in |-> !idle_bit_q && !pd_bit_q)
    else $error("reset level left a mode request set");

  a_kb_delay: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ST_PDOWN && pd_wake_kb && !pd_wake_int) |=> !cpu_clk_q[*8])
    else $error("keyboard wake resumed too early");

  c_idle_cycle: cover property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_IDLE ##[1:50] state_q == ST_RUN);
  c_pd_int_wake: cover property (@(posedge clock) disable iff (sys_rst)
    state_q == ST_PDOWN ##1 state_q == ST_WAIT_RELEASE ##[1:50] state_q == ST_RUN);
  c_wdt_reset: cover property (@(posedge clock) disable iff (sys_rst)
    $rose(wdt_drive_q) ##[1:40] core_reset_q);

endmodule
`default_nettype wire

// [verif/rip_reset_src.sv]
// Model of the external reset circuit and the internal watchdog source
`default_nettype none
module rip_reset_src (
  // Clock
  input  wire logic        clock,
  // Requests from the bench
  input  wire logic        go,
  input  wire logic [15:0] len,
  input  wire logic        wd_go,
  // Reset pin wire
  input  wire logic        pin_out,
  input  wire logic        pin_oe,
  output logic             pin_level,
  output logic             wd_fire
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always_ff @(posedge clock) begin
    if (go) cnt <= len;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // Pull-down holds the pin low when nobody drives it
  assign pin_level = (cnt > 0) | (pin_oe & pin_out);
  always_ff @(posedge clock) wd_fire <= wd_go;
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench of the reset, idle and power-down controller
`default_nettype none
module tb
  import rip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clock = 1'h0, sys_rst = 1'h1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, watchdog_fire, go = 1'h0, wd_go = 1'h0;
  logic irq_wake_req = 1'h0, ext_irq_line_0 = 1'h0, ext_irq_en_0 = 1'h1, keyboard_wake_inputs = 1'h0;
  logic boot_jump_fuse = 1'h0, core_reset, first_fetch, cpu_clk_en, periph_clk_en, osc_enable, ram_access_en;
  logic boot_map_enable, port0_float, mmc_float, ports_high, pin_hold, ff, cr;
  logic [15:0] fetch_addr, len = '0;
  int fails = 0, n_tests = 0, seed = 57, pm = 0, k;

  rip_power_ctrl DUT (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe, .watchdog_fire, .irq_wake_req, .ext_irq_line_0, .ext_irq_line_1(1'h0),
    .ext_irq_en_0, .ext_irq_en_1(1'h0), .keyboard_wake_inputs, .boot_jump_fuse, .core_reset, .first_fetch,
    .fetch_addr, .cpu_clk_en, .periph_clk_en, .osc_enable, .ram_access_en, .boot_map_enable, .port0_float,
    .mmc_float, .ports_high, .pin_hold);
  rip_reset_src u_src (.clock, .go, .len, .wd_go, .pin_out(reset_pin_out), .pin_oe(reset_pin_oe),
    .pin_level(reset_pin_in), .wd_fire(watchdog_fire));

  initial forever #5 clock = ~clock;
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (tk !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [11:0] a);
    logic ta, tk;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (tk !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask
  task automatic pin_reset(input logic [15:0] n);
    @(posedge clock);
    len <= n;
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
  endtask
  task automatic print_verdict();
    $display("counts: %0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bound sized for some fifteen hundred cycles of tests
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    print_verdict();
  end
  // ==========================================================
  // Tests; pm models the power config register
  initial begin
    boot_jump_fuse = $random(seed);
    repeat (20) @(posedge clock);
    sys_rst <= 1'h0;
    wt(3);
    chk("fetch_addr", fetch_addr, 0);
    chk("boot_map", boot_map_enable, boot_jump_fuse);
    axr(POWER_CONFIG_REG_ADDR);
    chk("power_config_reg reset", rd, pm);
    pm = $random(seed) & 32'hC;
    axw(POWER_CONFIG_REG_ADDR, pm);
    chk("write resp", resp, RESP_OKAY);
    axr(POWER_CONFIG_REG_ADDR);
    chk("flags", rd, pm);
    $display("test flags done");
    axw(POWER_CONFIG_REG_ADDR, pm | 1);
    wt(3);
    chk("idle cpu clk", cpu_clk_en, 0);
    chk("idle periph clk", periph_clk_en, 1);
    chk("idle pins", pin_hold, 1);
    @(posedge clock);
    irq_wake_req <= 1'h1;
    wt(4);
    chk("idle wake clk", cpu_clk_en, 1);
    irq_wake_req <= 1'h0;
    axr(POWER_CONFIG_REG_ADDR);
    chk("idle wake bit", rd, pm);
    $display("test idle done");
    axw(POWER_CONFIG_REG_ADDR, pm | 3);
    wt(3);
    chk("pd osc", osc_enable, 0);
    chk("pd cpu clk", cpu_clk_en, 0);
    chk("pd periph clk", periph_clk_en, 0);
    ext_irq_line_0 <= 1'h1;
    wt(5);
    chk("int wake osc", osc_enable, 1);
    chk("int wake hold", pin_hold, 1);
    ext_irq_line_0 <= 1'h0;
    wt(4);
    axr(STATUS_ADDR);
    chk("no idle after pd", rd[2:0], 0);
    axr(POWER_CONFIG_REG_ADDR);
    chk("pd bits clear", rd, pm);
    axw(POWER_CONFIG_REG_ADDR, pm | 2);
    wt(3);
    keyboard_wake_inputs <= 1'h1;
    wt(2);
    keyboard_wake_inputs <= 1'h0;
    wt(1000);
    chk("kb delay", pin_hold, 1);
    wt(40);
    chk("kb resume", pin_hold, 0);
    axr(12'h100);
    chk("unmapped resp", resp, RESP_SLVERR);
    chk("unmapped data", rd, 0);
    $display("test power-down done");
    pin_reset(16'h0014);
    cr = 1'h0;
    repeat (40) begin
      wt(1);
      if (core_reset !== 1'h0) cr = 1'h1;
    end
    chk("short reset", cr, 0);
    axw(POWER_CONFIG_REG_ADDR, pm | 1);
    wt(3);
    pin_reset(16'h0028);
    wt(4);
    chk("reset idle clk", cpu_clk_en, 1);
    chk("reset ram block", ram_access_en, 0);
    k = 0;
    while (core_reset !== 1'h1 && k < 60) begin
      wt(1);
      k++;
    end
    chk("reset pins", {port0_float, mmc_float, ports_high}, 3'h7);
    while (core_reset !== 1'h0 && k < 120) begin
      wt(1);
      k++;
    end
    ff = first_fetch;
    wt(1);
    chk("first fetch", ff | first_fetch, 1);
    axr(POWER_CONFIG_REG_ADDR);
    chk("power_config_reg after reset", rd, 0);
    $display("test pin reset done");
    @(posedge clock);
    wd_go <= 1'h1;
    @(posedge clock);
    wd_go <= 1'h0;
    k = 0;
    cr = 1'h0;
    repeat (300) begin
      wt(1);
      if (reset_pin_oe === 1'h1 && reset_pin_out === 1'h1) k++;
      if (core_reset === 1'h1) cr = 1'h1;
    end
    chk("wd pulse", k, 96);
    chk("wd reset", cr, 1);
    chk("wd boot map", boot_map_enable, boot_jump_fuse);
    $display("test watchdog done");
    print_verdict();
  end
endmodule
`default_nettype wire
